// ==== common/dec_exec_pkg.sv ====
// Package: constants for the decrement instruction execution block
package dec_exec_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int INSN_W = 14;
  localparam int OPC_W = 6;
  // Instruction field positions
  localparam int OPC_HI = 13;
  localparam int OPC_LO = 8;
  localparam int DEST_BIT = 7;
  localparam int ADDR_HI = 6;
  // Top bits 00, opcode 0011
  localparam logic [5:0] DEC_OPC = 6'h03;
  // Skip variant, top bits 00, opcode 1011
  localparam logic [5:0] DECSZ_OPC = 6'h0B;
  // Destination select codes
  localparam logic DEST_W = 1'h0;
  localparam logic DEST_F = 1'h1;
  // Reset values and arithmetic constants
  localparam logic [7:0] W_RST = 8'h00;
  localparam logic [7:0] ONE = 8'h01;
  localparam logic [7:0] ZERO = 8'h00;
  // Phase generator: four phases of one core clock each
  localparam int PHASE_DIV = 1;
  typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} phase_t;
endpackage

// ==== hdl/phase_gen.sv ====
// Four-phase instruction cycle sequencer
`timescale 1ns/1ps
module phase_gen
  import dec_exec_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic srst_i,
  output dec_exec_pkg::phase_t phase_o
);
  // -------------------------------
  // Phase counter
  // -------------------------------
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      phase_o <= PH_Q1;
    end else begin
      case (phase_o)
        PH_Q1: phase_o <= PH_Q2;
        PH_Q2: phase_o <= PH_Q3;
        PH_Q3: phase_o <= PH_Q4;
        default: phase_o <= PH_Q1;
      endcase
    end
  end
endmodule

// ==== hdl/decrement_instruction_exec.sv ====
// Decrement and decrement-skip-if-zero execution datapath
// Behaviour
// - Operands: 7-bit file address 0..127 and 1-bit destination select.
// - Result is file content minus one; decrement changes only the zero flag, the skip variant no flag.
// - Decrement decoded from 14-bit word 00 0011 d fffffff.
// - Destination 0 writes working register; 1 writes file register back.
// - One program word, completes in one instruction cycle.
// - Q1 decode, Q2 read, Q3 process, Q4 write; skip adds NOP cycle.
`timescale 1ns/1ps
module decrement_instruction_exec
  import dec_exec_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic [dec_exec_pkg::INSN_W-1:0] insn_i,
  input wire logic [dec_exec_pkg::DATA_W-1:0] rf_rdata_i,
  input wire logic zero_flag_i,
  output logic [dec_exec_pkg::ADDR_W-1:0] rf_addr_o,
  output logic rf_re_o,
  output logic [dec_exec_pkg::DATA_W-1:0] rf_wdata_o,
  output logic rf_we_o,
  output logic [dec_exec_pkg::DATA_W-1:0] wreg_o,
  output logic zero_flag_o,
  output logic zero_we_o,
  output logic skip_o,
  output logic pc_inc_o,
  output logic [1:0] phase_o,
  output logic busy_o
);
  import dec_exec_pkg::*;

  // -------------------------------
  // Phase sequencing
  // -------------------------------
  phase_t phase;

  phase_gen u_phase (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .phase_o(phase)
  );

  logic [OPC_W-1:0] opc_q;
  logic dest_q;
  logic is_dec_q;
  logic is_skip_q;
  logic [DATA_W-1:0] opnd_q;
  logic [DATA_W-1:0] res_q;
  logic nop_cycle_q;
  logic res_zero;
  logic [ADDR_W-1:0] insn_addr;

  assign res_zero = (res_q == ZERO);
  assign insn_addr = insn_i[ADDR_HI:0];

  // -------------------------------
  // Decode in Q1
  // -------------------------------
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      opc_q <= 6'h00;
      dest_q <= DEST_W;
      is_dec_q <= 1'b0;
      is_skip_q <= 1'b0;
      rf_addr_o <= 7'h00;
    end else if (phase == PH_Q1) begin
      opc_q <= insn_i[OPC_HI:OPC_LO];
      dest_q <= insn_i[DEST_BIT];
      rf_addr_o <= insn_addr;
      // Second cycle of a skip executes nothing at all
      is_dec_q <= !nop_cycle_q
        && insn_i[OPC_HI:OPC_LO] == DEC_OPC;
      is_skip_q <= !nop_cycle_q
        && insn_i[OPC_HI:OPC_LO] == DECSZ_OPC;
    end
  end

  // -------------------------------
  // Read in Q2, process in Q3
  // -------------------------------
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      rf_re_o <= 1'b0;
      opnd_q <= ZERO;
      res_q <= ZERO;
    end else begin
      // Strobe on every live Q1, not gated by decode; a file with
      // read side effects needs its own gating
      rf_re_o <= (phase == PH_Q1) && !nop_cycle_q;
      if (phase == PH_Q2) begin
        opnd_q <= rf_rdata_i;
      end
      if (phase == PH_Q3) begin
        res_q <= opnd_q - ONE;
      end
    end
  end

  // -------------------------------
  // Write back in Q4
  // -------------------------------
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      rf_we_o <= 1'b0;
      rf_wdata_o <= ZERO;
      wreg_o <= W_RST;
      zero_flag_o <= 1'b0;
      zero_we_o <= 1'b0;
    end else begin
      rf_we_o <= 1'b0;
      zero_we_o <= 1'b0;
      zero_flag_o <= zero_flag_i;
      if (phase == PH_Q4 && (is_dec_q || is_skip_q)) begin
        rf_wdata_o <= res_q;
        if (dest_q == DEST_W) begin
          wreg_o <= res_q;
        end else begin
          rf_we_o <= 1'b1;
        end
        // Skip variant leaves status alone; it writes the result and may skip
        if (is_dec_q) begin
          zero_flag_o <= res_zero;
          zero_we_o <= 1'b1;
        end
      end
    end
  end

  // -------------------------------
  // Skip and program counter
  // -------------------------------
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      nop_cycle_q <= 1'b0;
      skip_o <= 1'b0;
      pc_inc_o <= 1'b0;
    end else begin
      skip_o <= 1'b0;
      pc_inc_o <= (phase == PH_Q4);
      if (phase == PH_Q4) begin
        nop_cycle_q <= is_skip_q && res_zero;
        skip_o <= is_skip_q && res_zero;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      phase_o <= 2'h0;
      busy_o <= 1'b0;
    end else begin
      phase_o <= phase;
      busy_o <= nop_cycle_q;
    end
  end

  // -------------------------------
  // Checks
  // -------------------------------
  sequence s_dec_write;
    phase == PH_Q4 && is_dec_q;
  endsequence

  // Zero result of the skip variant in its last phase
  sequence s_skip_taken;
    phase == PH_Q4 && is_skip_q && res_zero;
  endsequence

  // Busy for four clocks, one clock behind the NOP cycle, then free again
  sequence s_nop_cycle;
    busy_o [*4] ##1 !busy_o;
  endsequence

  a_zero_flag_value: assert property (@(posedge core_clk_i)
    disable iff (srst_i) s_dec_write |=> zero_we_o
      && zero_flag_o == ($past(res_q) == ZERO))
    else $error("zero flag mismatch");
  a_result_minus_one: assert property (@(posedge core_clk_i)
    disable iff (srst_i) phase == PH_Q4 && (is_dec_q || is_skip_q)
      |=> rf_wdata_o == $past(opnd_q) - ONE)
    else $error("result not decremented");
  a_dest_file: assert property (@(posedge core_clk_i)
    disable iff (srst_i) (s_dec_write and dest_q == DEST_F) |=> rf_we_o)
    else $error("file register not written");
  a_dest_w_only: assert property (@(posedge core_clk_i)
    disable iff (srst_i) (s_dec_write and dest_q == DEST_W)
      |=> !rf_we_o && wreg_o == $past(res_q))
    else $error("working register not written");
  a_skip_on_zero: assert property (@(posedge core_clk_i)
    disable iff (srst_i) s_skip_taken
      |=> skip_o ##1 (!rf_re_o) [*4])
    else $error("skip not taken");
  a_no_skip_nonzero: assert property (@(posedge core_clk_i)
    disable iff (srst_i) phase == PH_Q4 && !res_zero |=> !skip_o)
    else $error("spurious skip");
  a_write_once_cycle: assert property (@(posedge core_clk_i)
    disable iff (srst_i) rf_we_o |=> (!rf_we_o) [*3])
    else $error("write not single cycle");
  a_read_in_q2: assert property (@(posedge core_clk_i)
    disable iff (srst_i) rf_re_o |-> phase == PH_Q2)
    else $error("read outside second phase");
  a_addr_capture: assert property (@(posedge core_clk_i)
    disable iff (srst_i) phase == PH_Q1
      |=> rf_addr_o == $past(insn_addr))
    else $error("file address not captured");
  a_decode_dec: assert property (@(posedge core_clk_i)
    disable iff (srst_i) is_dec_q |-> opc_q == DEC_OPC)
    else $error("decrement decoded from wrong opcode");
  a_pc_every_q4: assert property (@(posedge core_clk_i)
    disable iff (srst_i) phase == PH_Q4 |=> pc_inc_o ##1 (!pc_inc_o) [*3])
    else $error("program counter step not once per cycle");

  // -------------------------------
  // Skip and NOP cycle checks
  // -------------------------------
  a_decode_skip: assert property (@(posedge core_clk_i)
    disable iff (srst_i) is_skip_q |-> opc_q == DECSZ_OPC)
    else $error("skip variant decoded from wrong opcode");
  a_skip_no_status: assert property (@(posedge core_clk_i)
    disable iff (srst_i) phase == PH_Q4 && is_skip_q |=> !zero_we_o)
    else $error("skip variant touched the zero flag");
  a_nop_quiet: assert property (@(posedge core_clk_i)
    disable iff (srst_i) s_skip_taken
      |-> ##5 (!rf_we_o && !zero_we_o && !skip_o))
    else $error("skipped instruction still executed");
  a_busy_nop: assert property (@(posedge core_clk_i)
    disable iff (srst_i) s_skip_taken |-> ##2 s_nop_cycle)
    else $error("busy does not cover the NOP cycle");
endmodule

// ==== tb/decrement_instruction_exec_tb_top.sv ====
// Self-checking bench for the decrement execution block
`timescale 1ns/1ps
module decrement_instruction_exec_tb_top;
  import dec_exec_pkg::*;
  logic core_clk_i, srst_i, zero_flag_i;
  logic [INSN_W-1:0] insn_i;
  logic [DATA_W-1:0] rf_rdata_i, rf_wdata_o, wreg_o, last_wd;
  logic [ADDR_W-1:0] rf_addr_o, last_addr;
  logic rf_re_o, rf_we_o, zero_flag_o, zero_we_o, skip_o, pc_inc_o;
  logic busy_o, last_z;
  logic [1:0] phase_o;
  logic [7:0] n_we, n_zwe, n_skip, n_re, n_busy, n_pc;
  logic [1:0] last_ph;
  int n_fail = 0;
  int n_compared = 0;

  decrement_instruction_exec DUT (.core_clk_i(core_clk_i),
    .srst_i(srst_i), .insn_i(insn_i), .rf_rdata_i(rf_rdata_i),
    .zero_flag_i(zero_flag_i), .rf_addr_o(rf_addr_o), .rf_re_o(rf_re_o),
    .rf_wdata_o(rf_wdata_o), .rf_we_o(rf_we_o), .wreg_o(wreg_o),
    .zero_flag_o(zero_flag_o), .zero_we_o(zero_we_o), .skip_o(skip_o),
    .pc_inc_o(pc_inc_o), .phase_o(phase_o), .busy_o(busy_o));

  initial begin
    core_clk_i = 1'b0;
    forever #2 core_clk_i = ~core_clk_i;
  end

  // ----------
  // Monitor
  // ----------
  // Sticky counts, so pulse timing inside a window never races the checks
  always @(posedge core_clk_i) begin
    if (rf_we_o === 1'b1) begin
      n_we = n_we + 8'h01;
      last_wd = rf_wdata_o;
    end
    if (zero_we_o === 1'b1) begin
      n_zwe = n_zwe + 8'h01;
      last_z = zero_flag_o;
    end
    if (skip_o === 1'b1) n_skip = n_skip + 8'h01;
    if (rf_re_o === 1'b1) begin
      // First read of the window belongs to the instruction under test
      if (n_re == 8'h00) last_addr = rf_addr_o;
      n_re = n_re + 8'h01;
    end
    if (busy_o === 1'b1) n_busy = n_busy + 8'h01;
    if (pc_inc_o === 1'b1) begin
      n_pc = n_pc + 8'h01;
      last_ph = phase_o;
    end
  end

  task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Three back-to-back cycles of four edges keep the phase alignment
  task run(input logic [13:0] i1, input logic [13:0] i2, input logic [7:0] rd);
    n_we = 8'h00;
    n_zwe = 8'h00;
    n_skip = 8'h00;
    n_re = 8'h00;
    n_busy = 8'h00;
    n_pc = 8'h00;
    insn_i = i1;
    rf_rdata_i = rd;
    repeat (4) @(negedge core_clk_i);
    insn_i = i2;
    repeat (4) @(negedge core_clk_i);
    insn_i = 14'h0000;
    repeat (4) @(negedge core_clk_i);
  endtask

  task t_dec_w;
    run({DEC_OPC, DEST_W, 7'h7F}, 14'h0000, 8'h01);
    chk("wreg", wreg_o, ZERO);
    chk("addr", {1'b0, last_addr}, 8'h7F);
    chk("zero", {7'h00, last_z}, ONE);
    chk("zero_we", n_zwe, ONE);
    chk("file_we", n_we, ZERO);
    chk("pc_inc", n_pc, 8'h03);
    chk("phase", {6'h00, last_ph}, 8'h03);
    $display("test dec_to_w done");
  endtask

  task t_dec_f;
    zero_flag_i = 1'b1;
    run({DEC_OPC, DEST_F, 7'h00}, {6'h0A, 1'b1, 7'h01}, 8'h00);
    chk("wdata", last_wd, 8'hFF);
    chk("file_we", n_we, ONE);
    chk("zero", {7'h00, last_z}, ZERO);
    chk("zero_pass", {7'h00, zero_flag_o}, ONE);
    chk("wreg", wreg_o, ZERO);
    $display("test dec_to_f done");
  endtask

  task t_skip_zero;
    zero_flag_i = 1'b0;
    run({DECSZ_OPC, DEST_F, 7'h05}, {DEC_OPC, DEST_F, 7'h05}, ONE);
    chk("skip", n_skip, ONE);
    chk("file_we", n_we, ONE);
    chk("wdata", last_wd, ZERO);
    chk("zero_we", n_zwe, ZERO);
    chk("busy", n_busy, 8'h04);
    chk("reads", n_re, 8'h02);
    chk("pc_inc", n_pc, 8'h03);
    $display("test skip_zero done");
  endtask

  task t_skip_nz;
    run({DECSZ_OPC, DEST_W, 7'h05}, {DEC_OPC, DEST_F, 7'h05}, 8'h03);
    chk("skip", n_skip, ZERO);
    chk("wreg", wreg_o, 8'h02);
    chk("file_we", n_we, ONE);
    chk("wdata", last_wd, 8'h02);
    chk("zero_we", n_zwe, ONE);
    chk("zero", {7'h00, last_z}, ZERO);
    chk("busy", n_busy, ZERO);
    $display("test skip_nonzero done");
  endtask

  // Reset cuts a taken skip, so the pending NOP cycle must be dropped
  task t_reset;
    run({DEC_OPC, DEST_W, 7'h11}, 14'h0000, 8'h10);
    chk("wreg", wreg_o, 8'h0F);
    insn_i = {DECSZ_OPC, DEST_F, 7'h11};
    rf_rdata_i = ONE;
    repeat (4) @(negedge core_clk_i);
    srst_i = 1'b1;
    repeat (2) @(negedge core_clk_i);
    srst_i = 1'b0;
    chk("wreg_rst", wreg_o, W_RST);
    chk("busy_rst", {7'h00, busy_o}, ZERO);
    run({DEC_OPC, DEST_F, 7'h22}, 14'h0000, 8'h05);
    chk("file_we", n_we, ONE);
    chk("wdata", last_wd, 8'h04);
    chk("addr", {1'b0, last_addr}, 8'h22);
    chk("pc_inc", n_pc, 8'h02);
    $display("test mid_reset done");
  endtask

  task tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    srst_i = 1'b1;
    insn_i = 14'h0000;
    rf_rdata_i = 8'h00;
    zero_flag_i = 1'b0;
    repeat (12) @(negedge core_clk_i);
    srst_i = 1'b0;
    // One idle instruction, so every window before the mid-test reset opens on a Q4 pulse
    repeat (4) @(negedge core_clk_i);
    t_skip_nz;
    t_dec_w;
    t_dec_f;
    t_skip_zero;
    t_reset;
    tally_and_finish;
  end

  // Tests take about 95 cycles; allow ample margin
  initial begin
    #2000;
    n_fail++;
    tally_and_finish;
  end
endmodule
